// [fwsr_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
// How it works
// [RL1] program busy reads inverted written bit
// [RL2] poll bit valid after last command pulse
// [RL3] erase busy reads zero, done reads one
// [RL4] poll inside the target unprotected sector
// [RL5] re-read after poll bit matches
// [RL6] toggle bit flips every read while busy
// [RL7] toggle bit valid after last pulse
// [RL8] protected program toggles about 2 us
// [RL9] protected erase toggles about 100 us
// [RL10] timeout bit high means operation failed
// [RL11] after timeout bit, recheck toggling
// [RL12] programming zero to one causes timeout
// [RL13] on failure write reset command
// [RL14] erase timer bit rises at erase start
// [RL15] second toggle bit flips in erased sectors
// [RL16] combine both toggle bits for erase state
// [RL17] read twice and compare toggle bit
// [RL18] toggling with timeout: retest, fail resets
// [RL19] restart from first read after leaving
// [RL20] toggle bit steady when done or suspended
// [RL21] ignore unassigned status data lines
module fwsr_ctrl
    import fwsr_pkg::*;
#(
    parameter int unsigned MAX_POLLS = 65535
)
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_rstn,
    input  wire logic              i_start,
    input  wire logic              i_mode_toggle,
    input  wire logic              i_is_erase,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_expect,
    input  wire logic [DATA_W-1:0] i_dq_in,
    output logic                   o_ce_n,
    output logic                   o_oe_n,
    output logic                   o_we_n,
    output logic [ADDR_W-1:0]      o_addr,
    output logic [DATA_W-1:0]      o_dq_out,
    output logic                   o_dq_oe,
    output logic                   o_busy,
    output logic                   o_done,
    output logic [2:0]             o_result,
    output logic                   o_erase_active,
    output logic                   o_erase_suspended,
    output logic                   o_erase_started
);
    typedef enum logic [2:0] {
        FWSR_IDLE, FWSR_RD1, FWSR_RD2, FWSR_RETEST, FWSR_RD3, FWSR_RD4, FWSR_RST, FWSR_END
    } fwsr_state_t;

    fwsr_bus_if bus ();
    fwsr_state_t     st;
    fwsr_mode_t      mode;
    logic            erase;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] expect_d;
    logic [DATA_W-1:0] first;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic [31:0]     polls;
    logic [2:0]      res;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            dq_s1 <= '0;
            dq_s2 <= '0;
        end else begin
            dq_s1 <= i_dq_in;
            dq_s2 <= dq_s1;
        end
    end

    fwsr_cycle u_cycle (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .bus       (bus.slave),
        .i_dq_sync (dq_s2),
        .o_ce_n    (o_ce_n),
        .o_oe_n    (o_oe_n),
        .o_we_n    (o_we_n),
        .o_addr    (o_addr),
        .o_dq_out  (o_dq_out),
        .o_dq_oe   (o_dq_oe)
    );

    // [RL21] only status positions are compared
    wire [DATA_W-1:0] rd = bus.rdata;
    // [RL1] [RL3] expected poll level at completion
    wire poll_target = erase ? 1'b1 : expect_d[POLL_POS];
    wire poll_match  = rd[POLL_POS] == poll_target;
    wire tout_hi     = rd[TOUT_POS];
    // [RL6] [RL17] [RL20] toggle check on two consecutive reads
    wire tog1_moves  = rd[TOG1_POS] != first[TOG1_POS];
    wire tog2_moves  = rd[TOG2_POS] != first[TOG2_POS];
    wire cyc_done    = bus.done;
    wire give_up     = polls >= MAX_POLLS;
    // a read launched here would swallow the reset write that follows it
    wire rd2_quit    = give_up && !tout_hi &&
                       ((mode == FWSR_POLL_DATA) ? !poll_match : tog1_moves);

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st        <= FWSR_IDLE;
            mode      <= FWSR_POLL_DATA;
            erase     <= 1'b0;
            addr      <= '0;
            expect_d  <= '0;
            first     <= '0;
            polls     <= '0;
            res       <= RES_BUSY;
            bus.req   <= 1'b0;
            bus.wr    <= 1'b0;
            bus.addr  <= '0;
            bus.wdata <= '0;
            o_busy    <= 1'b0;
            o_done    <= 1'b0;
            o_result  <= RES_BUSY;
            o_erase_active    <= 1'b0;
            o_erase_suspended <= 1'b0;
            o_erase_started   <= 1'b0;
        end else begin
            bus.req <= 1'b0;
            o_done  <= 1'b0;
            unique case (st)
                FWSR_IDLE: if (i_start) begin
                    // [RL2] [RL7] [RL4] start only after final command pulse, own sector
                    mode      <= i_mode_toggle ? FWSR_POLL_TOGGLE : FWSR_POLL_DATA;
                    erase     <= i_is_erase;
                    addr      <= i_addr;
                    expect_d  <= i_expect;
                    polls     <= '0;
                    o_busy    <= 1'b1;
                    o_erase_started <= 1'b0;
                    bus.req   <= 1'b1;
                    bus.wr    <= 1'b0;
                    bus.addr  <= i_addr;
                    st        <= FWSR_RD1;
                end
                FWSR_RD1: if (cyc_done) begin
                    first   <= rd;
                    polls   <= polls + 32'h0000_0001;
                    // [RL14] erase timer shows the erase has begun
                    o_erase_started <= erase & rd[ETMR_POS];
                    bus.req <= 1'b1;
                    st      <= FWSR_RD2;
                end
                FWSR_RD2: if (cyc_done) begin
                    bus.req <= !rd2_quit;
                    if (mode == FWSR_POLL_DATA) begin
                        // [RL5] poll matched: re-read to get all lines valid
                        if (poll_match) begin
                            st <= FWSR_RD4;
                        end else if (tout_hi) begin
                            st <= FWSR_RD3;
                        end else begin
                            st <= give_up ? FWSR_RST : FWSR_RD1;
                        end
                    end else begin
                        // [RL16] suspended: first toggle steady, second moving
                        o_erase_active    <= erase & tog1_moves;
                        o_erase_suspended <= erase & !tog1_moves & tog2_moves;
                        if (!tog1_moves) begin
                            st <= FWSR_RD4;
                        end else if (tout_hi) begin
                            // [RL11] [RL18] timeout seen, retest toggling
                            st <= FWSR_RETEST;
                        end else begin
                            // [RL19] keep monitoring from the first read
                            st <= give_up ? FWSR_RST : FWSR_RD1;
                        end
                    end
                end
                FWSR_RETEST: if (cyc_done) begin
                    // [RL18] the retest compares two fresh reads
                    first   <= rd;
                    bus.req <= 1'b1;
                    st      <= FWSR_RD3;
                end
                FWSR_RD3: if (cyc_done) begin
                    // [RL10] [RL12] still busy after timeout is a failure
                    if ((mode == FWSR_POLL_DATA) ? poll_match : !tog1_moves) begin
                        res     <= RES_DONE;
                        bus.req <= 1'b1;
                        st      <= FWSR_RD4;
                    end else begin
                        res <= RES_FAIL;
                        st  <= FWSR_RST;
                    end
                end
                FWSR_RD4: if (cyc_done) begin
                    res <= RES_DONE;
                    st  <= FWSR_END;
                end
                FWSR_RST: begin
                    // [RL13] reset command returns the device to array reads
                    bus.req   <= 1'b1;
                    bus.wr    <= 1'b1;
                    bus.addr  <= addr;
                    bus.wdata <= CMD_RESET;
                    if (res != RES_FAIL) begin
                        res <= RES_TIMEOUT;
                    end
                    st <= FWSR_END;
                end
                FWSR_END: if (!bus.req && (bus.wr ? cyc_done : 1'b1)) begin
                    bus.wr   <= 1'b0;
                    o_busy   <= 1'b0;
                    o_done   <= 1'b1;
                    o_result <= res;
                    o_erase_active    <= 1'b0;
                    o_erase_suspended <= 1'b0;
                    res      <= RES_BUSY;
                    st       <= FWSR_IDLE;
                end
            endcase
        end
    end
    // [RL8] [RL9] a protected target stops toggling by itself and reads done
endmodule : fwsr_ctrl
`default_nettype wire

// [fwsr_pkg.sv]
package fwsr_pkg;
    localparam int unsigned CLK_PERIOD_NS   = 10;
    // chosen bus timing of one flash access, in ns, with margin over a fast part
    localparam int unsigned T_ACC_NS        = 70;
    localparam int unsigned T_WP_NS         = 50;
    localparam int unsigned T_GAP_NS        = 30;
    localparam int unsigned ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WP_CYC  = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned GAP_CYC = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ADDR_W  = 19;
    localparam int unsigned DATA_W  = 8;
    localparam int unsigned POLL_POS    = 7;
    localparam int unsigned TOG1_POS    = 6;
    localparam int unsigned TOUT_POS    = 5;
    localparam int unsigned ETMR_POS    = 3;
    localparam int unsigned TOG2_POS    = 2;
    localparam logic [7:0]  CMD_RESET   = 8'hF0;
    localparam logic [2:0]  RES_BUSY    = 3'h0;
    localparam logic [2:0]  RES_DONE    = 3'h1;
    localparam logic [2:0]  RES_FAIL    = 3'h2;
    localparam logic [2:0]  RES_TIMEOUT = 3'h3;
    typedef enum logic [1:0] {FWSR_POLL_DATA, FWSR_POLL_TOGGLE} fwsr_mode_t;
endpackage : fwsr_pkg

// [fwsr_bus_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface fwsr_bus_if;
    import fwsr_pkg::*;
    logic              req;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              done;
    logic [DATA_W-1:0] rdata;
    modport master (output req, output wr, output addr, output wdata,
                    input done, input rdata);
    modport slave  (input req, input wr, input addr, input wdata,
                    output done, output rdata);
endinterface : fwsr_bus_if
`default_nettype wire

// [fwsr_cycle.sv]
`timescale 1ns/10ps
`default_nettype none
// one asynchronous read or write cycle on the flash pins
module fwsr_cycle
    import fwsr_pkg::*;
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_rstn,
    fwsr_bus_if.slave              bus,
    input  wire logic [DATA_W-1:0] i_dq_sync,
    output logic                   o_ce_n,
    output logic                   o_oe_n,
    output logic                   o_we_n,
    output logic [ADDR_W-1:0]      o_addr,
    output logic [DATA_W-1:0]      o_dq_out,
    output logic                   o_dq_oe
);
    typedef enum logic [1:0] {FWSR_C_IDLE, FWSR_C_ACT, FWSR_C_GAP} fwsr_cst_t;
    fwsr_cst_t  st;
    logic [7:0] cnt;
    // sync adds two cycles of latency, so the read window is stretched by two
    localparam logic [7:0] RD_LEN = 8'(ACC_CYC + 2);
    localparam logic [7:0] WR_LEN = 8'(WP_CYC);
    localparam logic [7:0] GP_LEN = 8'(GAP_CYC);
    wire cnt_end = (cnt == 8'h00);

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st       <= FWSR_C_IDLE;
            cnt      <= 8'h00;
            o_ce_n   <= 1'b1;
            o_oe_n   <= 1'b1;
            o_we_n   <= 1'b1;
            o_addr   <= '0;
            o_dq_out <= '0;
            o_dq_oe  <= 1'b0;
            bus.done <= 1'b0;
            bus.rdata <= '0;
        end else begin
            bus.done <= 1'b0;
            unique case (st)
                FWSR_C_IDLE: if (bus.req) begin
                    st       <= FWSR_C_ACT;
                    o_addr   <= bus.addr;
                    o_dq_out <= bus.wdata;
                    o_dq_oe  <= bus.wr;
                    o_ce_n   <= 1'b0;
                    o_oe_n   <= bus.wr;
                    o_we_n   <= !bus.wr;
                    cnt      <= bus.wr ? WR_LEN : RD_LEN;
                end
                FWSR_C_ACT: if (cnt_end) begin
                    // oe/ce rising ends the read; the next read is a fresh one
                    st        <= FWSR_C_GAP;
                    o_ce_n    <= 1'b1;
                    o_oe_n    <= 1'b1;
                    o_we_n    <= 1'b1;
                    bus.rdata <= i_dq_sync;
                    cnt       <= GP_LEN;
                end else begin
                    cnt <= cnt - 8'h01;
                end
                FWSR_C_GAP: if (cnt_end) begin
                    st       <= FWSR_C_IDLE;
                    o_dq_oe  <= 1'b0;
                    bus.done <= 1'b1;
                end else begin
                    cnt <= cnt - 8'h01;
                end
            endcase
        end
    end
endmodule : fwsr_cycle
`default_nettype wire

// [fwsr_ctrl_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module fwsr_ctrl_monitor
    import fwsr_pkg::*;
(
    input wire logic              i_sys_clk,
    input wire logic              i_rstn,
    input wire logic              i_start,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic              o_ce_n,
    input wire logic              o_oe_n,
    input wire logic              o_we_n,
    input wire logic [ADDR_W-1:0] o_addr,
    input wire logic [DATA_W-1:0] o_dq_out,
    input wire logic              o_dq_oe,
    input wire logic              o_busy,
    input wire logic              o_done,
    input wire logic [2:0]        o_result,
    input wire logic              o_erase_active,
    input wire logic              o_erase_suspended
);
    logic [ADDR_W-1:0] addr_q;
    logic              wrote_rst;
    logic [3:0]        nrd;
    // reads counted per operation; saturates so long polls never wrap
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            addr_q    <= '0;
            wrote_rst <= 1'b0;
            nrd       <= 4'h0;
        end else if (i_start && !o_busy) begin
            addr_q    <= i_addr;
            wrote_rst <= 1'b0;
            nrd       <= 4'h0;
        end else begin
            wrote_rst <= wrote_rst | (!o_we_n && o_dq_oe && o_dq_out == CMD_RESET);
            nrd       <= nrd + {3'h0, $rose(o_oe_n) && nrd != 4'hF};
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_read_open; $fell(o_oe_n); endsequence
    sequence s_read_held; (!o_oe_n && !o_ce_n)[*8]; endsequence
    a_read_held: assert property (s_read_open |-> s_read_held)
        else $error("read strobe released early");
    a_start_busy: assert property (i_start && !o_busy |=> o_busy)
        else $error("start not taken");
    a_done_idle: assert property (o_done |=> !o_done && !o_busy && o_ce_n && o_oe_n)
        else $error("bus not idle after done");
    a_poll_addr: assert property (o_busy && !o_ce_n |-> o_addr == addr_q)
        else $error("access away from polled address");
    a_no_contention: assert property (!o_oe_n |-> !o_dq_oe && o_we_n)
        else $error("drive during read");
    a_fail_resets: assert property (o_done && o_result != RES_DONE |-> wrote_rst)
        else $error("failure without reset command");
    a_pass_reread: assert property (o_done && o_result == RES_DONE |-> !wrote_rst && nrd >= 4'h2)
        else $error("success without second read");
    a_result_hold: assert property ($changed(o_result) |-> o_done)
        else $error("result changed outside done");
    a_erase_flags: assert property (!(o_erase_active && o_erase_suspended))
        else $error("erase active and suspended");
endmodule : fwsr_ctrl_monitor
bind fwsr_ctrl fwsr_ctrl_monitor i_mon (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_start(i_start),
    .i_addr(i_addr), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_addr(o_addr),
    .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .o_busy(o_busy), .o_done(o_done),
    .o_result(o_result), .o_erase_active(o_erase_active), .o_erase_suspended(o_erase_suspended));
`default_nettype wire

// [fwsr_flash_model.sv]
`timescale 1ns/10ps
`default_nettype none
module fwsr_flash_model
    import fwsr_pkg::*;
(
    input  wire logic              i_ce_n,
    input  wire logic              i_oe_n,
    input  wire logic              i_we_n,
    input  wire logic [DATA_W-1:0] i_dq,
    input  wire logic              i_arm,
    input  wire logic              i_erase,
    input  wire logic              i_stuck,
    input  wire logic [DATA_W-1:0] i_data,
    input  wire logic [15:0]       i_busy_reads,
    input  wire logic [15:0]       i_tout_at,
    output logic      [DATA_W-1:0] o_dq
);
    logic [15:0] reads = 16'h0000;
    logic        busy = 1'b0;
    logic        tog = 1'b0;
    logic        rd_open = 1'b0;
    logic [7:0]  held = 8'h00;
    wire  [7:0]  stat;
    wire  [7:0]  arr;
    // status byte, spare lines carry junk
    assign stat = {i_erase ? 1'b0 : ~i_data[7], tog, reads >= i_tout_at, 1'b0,
                   i_erase, i_erase & tog, 2'h2};
    assign arr = i_erase ? 8'hFF : i_data;
    // released bus shows the inverse of the last byte
    assign o_dq = (i_ce_n === 1'b0 && i_oe_n === 1'b0) ? (busy ? stat : arr) : ~held;
    // status valid once the last command pulse arms it
    always @(posedge i_arm) begin
        reads = 16'h0000;
        busy = 1'b1;
    end
    // a read ends on either strobe rising; toggle only while busy
    always @(i_ce_n or i_oe_n) begin
        if (i_ce_n === 1'b0 && i_oe_n === 1'b0) begin
            rd_open = 1'b1;
        end else if (rd_open) begin
            rd_open = 1'b0;
            held = busy ? stat : arr;
            if (busy) begin
                reads = reads + 16'h0001;
                tog = ~tog;
                // a protected target stops after a few reads
                busy = i_stuck || reads < i_busy_reads;
            end
        end
    end
    // reset command returns to array reads
    always @(i_ce_n or i_we_n or i_dq) begin
        if (i_ce_n === 1'b0 && i_we_n === 1'b0 && i_dq === CMD_RESET) begin
            busy = 1'b0;
        end
    end
endmodule : fwsr_flash_model
`default_nettype wire

// [fwsr_ctrl_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module fwsr_ctrl_tb;
    import fwsr_pkg::*;
    logic              clk, rstn, start, mode, erase, arm, stuck;
    logic [DATA_W-1:0] data;
    logic [15:0]       nbusy, ntout;
    logic [ADDR_W-1:0] addr, o_addr;
    logic [DATA_W-1:0] dq_out, mdq, dq_in;
    logic [2:0]        res;
    logic              ce_n, oe_n, we_n, dq_oe, busy, done, e_act, e_sus, e_start;
    logic              act_seen;
    int                n_mismatch = 0;
    int                checks_done = 0;
    int                cycles = 0;
    assign dq_in = dq_oe ? dq_out : mdq;
    fwsr_ctrl #(.MAX_POLLS(20)) i_fwsr_ctrl (.i_sys_clk(clk), .i_rstn(rstn), .i_start(start),
        .i_mode_toggle(mode), .i_is_erase(erase), .i_addr(addr), .i_expect(data),
        .i_dq_in(dq_in), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_addr(o_addr),
        .o_dq_out(dq_out), .o_dq_oe(dq_oe), .o_busy(busy), .o_done(done), .o_result(res),
        .o_erase_active(e_act), .o_erase_suspended(e_sus), .o_erase_started(e_start));
    fwsr_flash_model i_fwsr_flash_model (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
        .i_dq(dq_out), .i_arm(arm), .i_erase(erase), .i_stuck(stuck), .i_data(data),
        .i_busy_reads(nbusy), .i_tout_at(ntout), .o_dq(mdq));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic run_op(input string nm, input logic m, e, s, input logic [7:0] d,
                          input logic [15:0] nb, nt, input logic [2:0] exp_res);
        int n;
        @(posedge clk);
        #1 {mode, erase, stuck, data, nbusy, ntout} = {m, e, s, d, nb, nt};
        {start, arm} = 2'h3;
        @(posedge clk);
        #1 {start, arm} = 2'h0;
        n = 0;
        act_seen = 1'b0;
        while (done !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1 n++;
            act_seen = act_seen | e_act;
        end
        check({7'h0, done}, 8'h01);
        check({5'h0, res}, {5'h0, exp_res});
        $display("test %s ended", nm);
    endtask : run_op
    task automatic t_prog_poll;
        run_op("prog_poll", 0, 0, 0, 8'hA5, 16'h3, 16'hFFFF, RES_DONE);
    endtask : t_prog_poll
    task automatic t_prog_toggle;
        run_op("prog_toggle", 1, 0, 0, 8'h3C, 16'h4, 16'hFFFF, RES_DONE);
        check({7'h0, act_seen}, 8'h00);
    endtask : t_prog_toggle
    task automatic t_erase_toggle;
        run_op("erase_toggle", 1, 1, 0, 8'hFF, 16'h3, 16'hFFFF, RES_DONE);
        check({7'h0, e_start}, 8'h01);
        check({7'h0, act_seen}, 8'h01);
    endtask : t_erase_toggle
    task automatic t_erase_poll;
        run_op("erase_poll", 0, 1, 0, 8'hFF, 16'h2, 16'hFFFF, RES_DONE);
    endtask : t_erase_poll
    task automatic t_toggle_fail;
        run_op("toggle_fail", 1, 0, 1, 8'h0F, 16'h2, 16'h2, RES_FAIL);
    endtask : t_toggle_fail
    task automatic t_poll_fail;
        run_op("poll_fail", 0, 0, 1, 8'hF0, 16'h2, 16'h1, RES_FAIL);
    endtask : t_poll_fail
    task automatic t_late_error;
        // error bit is high on the second pair of status reads, then the device finishes
        run_op("late_error", 1, 0, 0, 8'h3C, 16'h4, 16'h2, RES_DONE);
    endtask : t_late_error
    task automatic t_poll_limit;
        run_op("poll_limit", 1, 0, 0, 8'h11, 16'h03E8, 16'hFFFF, RES_TIMEOUT);
    endtask : t_poll_limit
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        {rstn, start, mode, erase, arm, stuck} = 6'h0;
        {data, nbusy, ntout, addr} = {8'h00, 16'h0, 16'h0, 19'h21000};
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        t_prog_poll();
        t_prog_toggle();
        t_erase_toggle();
        t_erase_poll();
        t_toggle_fail();
        t_poll_fail();
        t_late_error();
        t_poll_limit();
        finish_test();
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_mismatch++;
            finish_test();
        end
    end
endmodule : fwsr_ctrl_tb
`default_nettype wire
